/* File: verilog/clm_pkg.sv */
// Shared types, timing table and constants for the logic, move and bit execution core.
// Overview of operation
// RL1 - AND, OR, XOR work on each bit independently.
// RL2 - Accumulator logic ops: register 1/1, direct/immediate 2/2, indirect 1/2.
// RL3 - Direct-byte logic ops: 3 cycles, 2 or 3 bytes.
// RL4 - Clear, complement, rotates: one byte, one cycle.
// RL5 - Nibble swap of accumulator, one byte, one cycle.
// RL6 - Core moves use direct, indirect, register, immediate operands.
// RL7 - External moves: accumulator only, indirect address only.
// RL8 - External moves one byte; 4/3 read, 5/4 write.
// RL9 - Code lookups read program memory: 5 or 4 cycles.
// RL10 - Register/accumulator 1 cycle; direct to register 3; direct-direct 3/3.
// RL11 - Data pointer immediate load: 3 bytes, 3 cycles.
// RL12 - Push 2 bytes 3 cycles; pop 2 bytes 2 cycles.
// RL13 - Exchange: register 2, direct/indirect 3; low digit 1/3.
// RL14 - 128 bit-addressable RAM bits plus bit-addressable registers.
// RL15 - Carry ops 1/1; direct bit ops 2/3.
// RL16 - Carry AND/OR with bit or its complement, 2/2.
// RL17 - Bit to carry 2/2; carry to bit 2/3.
// RL18 - Carry-conditional relative jumps: 2 bytes, 3 cycles.
// RL19 - Bit jumps 3/5; clearing variant clears a set bit.
// RL20 - Indirect uses register 0/1 or data pointer.
// RL21 - Bit operand selects one of 256 bits.
// RL22 - Next instruction starts after the cycle count elapses.
// RL23 - Carry rotates form a 9-bit ring; plain rotates skip carry.
package clm_pkg;
	localparam logic [7:0] SP_RESET = 8'h07;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] DP_RESET = 16'h0000;
	localparam logic [3:0] BIT_RAM_HI = 4'h2;
	localparam logic [7:0] PTR_PAGE = 8'h00;
	localparam int RAM_DEPTH = 256;
	localparam logic [2:0] CYC_ONE = 3'h1;

	// Operations the core executes.
	typedef enum logic [5:0] {
		nop_op, and_op, or_op, xor_op, clear_acc_op, complement_op, rotate_left_op,
		rotate_left_carry_op, rotate_right_op, rotate_right_carry_op, swap_op, move_op,
		load_pointer_op, code_lookup_op, code_lookup_pc_op, external_read_op, external_write_op,
		push_op, pop_op, exchange_op, low_digit_exchange_op, carry_clear_op, carry_set_op,
		carry_complement_op, bit_clear_op, bit_set_op, bit_complement_op, carry_and_bit_op,
		carry_and_not_bit_op, carry_or_bit_op, carry_or_not_bit_op, bit_to_carry_op,
		carry_to_bit_op, jump_on_carry, jump_on_no_carry, jump_on_bit, jump_on_no_bit,
		jump_on_bit_and_clear
	} clm_op_t;

	// Operand locations: accumulator, working register, direct, indirect, immediate.
	typedef enum logic [2:0] {LOC_ACC, LOC_REG, LOC_DIR, LOC_IND, LOC_IMM} clm_loc_t;

	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BUSY = 2'b10} clm_state_t;

	// Returns {length in bytes, cycles} for one instruction.
	function automatic logic [4:0] clm_timing(clm_op_t op, clm_loc_t dst, clm_loc_t src);
		logic [1:0] len;
		logic [2:0] cyc;
		len = 2'd1 + {1'b0, src inside {LOC_DIR, LOC_IMM}} + {1'b0, dst == LOC_DIR};
		cyc = CYC_ONE;
		case (op)
			and_op, or_op, xor_op: cyc = (dst == LOC_DIR) ? 3'd3 : (src == LOC_REG) ? 3'd1 : 3'd2; // RL2 RL3
			move_op: begin
				if ((dst == LOC_ACC && src == LOC_REG) || (dst == LOC_REG && src == LOC_ACC)) begin
					cyc = 3'd1; // RL10
				end else if ((src == LOC_DIR && dst != LOC_ACC) || (dst == LOC_DIR && src inside {LOC_IND, LOC_IMM})) begin
					cyc = 3'd3; // RL10
				end else begin
					cyc = 3'd2;
				end
			end
			load_pointer_op: begin len = 2'd3; cyc = 3'd3; end // RL11
			code_lookup_op: begin len = 2'd1; cyc = 3'd5; end // RL9
			code_lookup_pc_op: begin len = 2'd1; cyc = 3'd4; end // RL9
			external_read_op: begin len = 2'd1; cyc = (src == LOC_IND) ? 3'd4 : 3'd3; end // RL8
			external_write_op: begin len = 2'd1; cyc = (dst == LOC_IND) ? 3'd5 : 3'd4; end // RL8
			push_op: begin len = 2'd2; cyc = 3'd3; end // RL12
			pop_op: begin len = 2'd2; cyc = 3'd2; end // RL12
			exchange_op: begin
				len = (src == LOC_DIR) ? 2'd2 : 2'd1;
				cyc = (src == LOC_REG) ? 3'd2 : 3'd3; // RL13
			end
			low_digit_exchange_op: begin len = 2'd1; cyc = 3'd3; end // RL13
			bit_clear_op, bit_set_op, bit_complement_op, carry_to_bit_op: begin
				len = 2'd2; // RL15 RL17
				cyc = 3'd3;
			end
			carry_and_bit_op, carry_and_not_bit_op, carry_or_bit_op, carry_or_not_bit_op, bit_to_carry_op: begin
				len = 2'd2; // RL16 RL17
				cyc = 3'd2;
			end
			jump_on_carry, jump_on_no_carry: begin len = 2'd2; cyc = 3'd3; end // RL18
			jump_on_bit, jump_on_no_bit, jump_on_bit_and_clear: begin len = 2'd3; cyc = 3'd5; end // RL19
			default: begin len = 2'd1; cyc = CYC_ONE; end // RL4 RL5 RL15
		endcase
		return {len, cyc};
	endfunction
endpackage

/* File: verilog/clm_ram_if.sv */
// Internal RAM port bundle between the core and its storage.
`timescale 1ns/10ps
`default_nettype none
interface clm_ram_if;
	logic [7:0] ra_a, ra_b, ra_p, rd_a, rd_b, rd_p, wa, wd;
	logic we;
	modport core (output ra_a, ra_b, ra_p, we, wa, wd, input rd_a, rd_b, rd_p);
	modport ram (input ra_a, ra_b, ra_p, we, wa, wd, output rd_a, rd_b, rd_p);
endinterface
`default_nettype wire

/* File: verilog/clm_ram.sv */
// Internal RAM and special-function byte storage with three read ports and one write port.
`timescale 1ns/10ps
`default_nettype none
module clm_ram import clm_pkg::*; (
	input wire logic ref_clk, // Core clock.
	input wire logic rst, // Asynchronous reset, active high.
	clm_ram_if.ram bus // Read and write ports.
);
	logic [7:0] mem_q [RAM_DEPTH];
	logic [7:0] mem_d [RAM_DEPTH];

	// Next contents: one byte written per cycle.
	always_comb begin
		mem_d = mem_q;
		if (bus.we) begin
			mem_d[bus.wa] = bus.wd;
		end
	end

	// Storage flip-flops.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < RAM_DEPTH; i++) begin
				mem_q[i] <= 8'h00;
			end
		end else begin
			mem_q <= mem_d;
		end
	end

	// Reads see the current contents in the same cycle.
	assign bus.rd_a = mem_q[bus.ra_a];
	assign bus.rd_b = mem_q[bus.ra_b];
	assign bus.rd_p = mem_q[bus.ra_p];
endmodule
`default_nettype wire

/* File: verilog/clm_alu.sv */
// Byte logic unit for accumulator and direct-byte logic operations.
`timescale 1ns/10ps
`default_nettype none
module clm_alu import clm_pkg::*; (
	input wire clm_op_t op, // Operation.
	input wire logic [7:0] a, // Destination operand.
	input wire logic [7:0] b, // Source operand.
	input wire logic cy_in, // Carry in.
	output logic [7:0] res, // Result byte.
	output logic cy_out // Carry out.
);
	logic [7:0] and_v, or_v, xor_v;

	// Each result bit depends only on the two bits at its own position.
	for (genvar i = 0; i < 8; i++) begin : g_bit
		assign and_v[i] = a[i] & b[i]; // RL1
		assign or_v[i] = a[i] | b[i]; // RL1
		assign xor_v[i] = a[i] ^ b[i]; // RL1
	end

	// Result select; only the carry rotates touch the carry.
	always_comb begin
		res = a;
		cy_out = cy_in;
		case (op)
			and_op: res = and_v;
			or_op: res = or_v;
			xor_op: res = xor_v;
			clear_acc_op: res = 8'h00; // RL4
			complement_op: res = ~a; // RL4
			rotate_left_op: res = {a[6:0], a[7]}; // RL23
			rotate_right_op: res = {a[0], a[7:1]}; // RL23
			rotate_left_carry_op: begin
				res = {a[6:0], cy_in}; // RL23
				cy_out = a[7];
			end
			rotate_right_carry_op: begin
				res = {cy_in, a[7:1]}; // RL23
				cy_out = a[0];
			end
			swap_op: res = {a[3:0], a[7:4]}; // RL5
			default: res = a;
		endcase
	end
endmodule
`default_nettype wire

/* File: verilog/clm_core.sv */
// Execution core for the logic, data transfer and bit instruction groups.
`timescale 1ns/10ps
`default_nettype none
module clm_core import clm_pkg::*; (
	input wire logic ref_clk, // Core clock, 20 MHz.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic issue_valid, // Instruction offered.
	input wire clm_op_t issue_op, // Operation.
	input wire clm_loc_t issue_dst, // Destination location.
	input wire clm_loc_t issue_src, // Source location.
	input wire logic [2:0] issue_rsel, // Working register number.
	input wire logic [7:0] issue_arg1, // First operand byte.
	input wire logic [7:0] issue_arg2, // Second operand byte.
	output logic issue_ready, // Core takes an instruction this cycle.
	output logic retire, // Pulse: instruction finished.
	output logic [7:0] acc, // Accumulator.
	output logic carry, // Carry flag.
	output logic [15:0] pc, // Program counter.
	output logic [15:0] data_pointer, // Data pointer.
	output logic [7:0] stack_ptr, // Stack pointer.
	output logic [15:0] x_addr, // External data address.
	output logic [7:0] x_wdata, // External write data.
	output logic x_wr, // Pulse: external write.
	output logic x_rd, // Pulse: external read.
	input wire logic [7:0] x_rdata, // External read data, cycle after x_rd.
	output logic [15:0] c_addr, // Program memory address.
	output logic c_rd, // Pulse: program memory read.
	input wire logic [7:0] c_rdata // Program memory data, cycle after c_rd.
);
	clm_ram_if rb ();

	clm_state_t st_q, st_d;
	logic [2:0] cnt_q, cnt_d;
	logic ready_q, ready_d, retire_q, retire_d;
	logic [1:0] pend_q, pend_d;
	logic [7:0] acc_q, acc_d, sp_q, sp_d;
	logic cy_q, cy_d;
	logic [15:0] pc_q, pc_d, dp_q, dp_d, xa_q, xa_d, ca_q, ca_d;
	logic [7:0] xw_q, xw_d;
	logic xwr_q, xwr_d, xrd_q, xrd_d, crd_q, crd_d;
	logic accept;
	logic [1:0] dec_len;
	logic [2:0] dec_cyc;
	logic [7:0] ptr, reg_addr, byte2, bit_byte, src_addr, dst_addr, src_val, alu_a, alu_res, rel;
	logic [2:0] bit_idx;
	logic bit_val, alu_cy, is_bit, taken;
	logic [15:0] pc_seq, rel16;
	clm_ram u_ram (
		.ref_clk(ref_clk),
		.rst(rst),
		.bus(rb)
	);
	clm_alu u_alu (
		.op(issue_op),
		.a(alu_a),
		.b(src_val),
		.cy_in(cy_q),
		.res(alu_res),
		.cy_out(alu_cy)
	);
	// Decode of operand addresses and values for the offered instruction.
	assign accept = issue_valid && ready_q;
	assign {dec_len, dec_cyc} = clm_timing(issue_op, issue_dst, issue_src);
	assign reg_addr = {5'h00, issue_rsel};
	assign ptr = rb.rd_p; // RL20
	assign byte2 = (issue_dst == LOC_DIR) ? issue_arg2 : issue_arg1;
	assign bit_byte = issue_arg1[7] ? {issue_arg1[7:3], 3'h0} : {BIT_RAM_HI, issue_arg1[6:3]}; // RL14 RL21
	assign bit_idx = issue_arg1[2:0]; // RL21
	assign is_bit = issue_op inside {bit_clear_op, bit_set_op, bit_complement_op, carry_and_bit_op,
		carry_and_not_bit_op, carry_or_bit_op, carry_or_not_bit_op, bit_to_carry_op, carry_to_bit_op,
		jump_on_bit, jump_on_no_bit, jump_on_bit_and_clear};
	assign bit_val = rb.rd_a[bit_idx];
	assign alu_a = (issue_dst == LOC_DIR) ? rb.rd_b : acc_q;
	assign rel = issue_op inside {jump_on_carry, jump_on_no_carry} ? issue_arg1 : issue_arg2;
	assign rel16 = {{8{rel[7]}}, rel};
	assign pc_seq = pc_q + {14'h0000, dec_len};
	// Source and destination byte addresses in internal RAM.
	always_comb begin
		src_addr = 8'h00;
		dst_addr = 8'h00;
		if (is_bit) begin
			src_addr = bit_byte;
			dst_addr = bit_byte;
		end else if (issue_op == push_op) begin
			src_addr = issue_arg1;
			dst_addr = 8'(sp_q + 8'h01);
		end else if (issue_op == pop_op) begin
			src_addr = sp_q;
			dst_addr = issue_arg1;
		end else begin
			case (issue_src)
				LOC_REG: src_addr = reg_addr;
				LOC_DIR: src_addr = byte2;
				LOC_IND: src_addr = ptr; // RL20
				default: src_addr = 8'h00;
			endcase
			case (issue_dst)
				LOC_REG: dst_addr = reg_addr;
				LOC_DIR: dst_addr = issue_arg1;
				LOC_IND: dst_addr = ptr; // RL20
				default: dst_addr = 8'h00;
			endcase
		end
	end
	// Source operand value.
	always_comb begin
		case (issue_src)
			LOC_IMM: src_val = byte2;
			LOC_ACC: src_val = acc_q;
			default: src_val = rb.rd_a; // RL6
		endcase
	end
	// Branch condition for the conditional jumps.
	always_comb begin
		case (issue_op)
			jump_on_carry: taken = cy_q; // RL18
			jump_on_no_carry: taken = !cy_q; // RL18
			jump_on_bit, jump_on_bit_and_clear: taken = bit_val; // RL19
			jump_on_no_bit: taken = !bit_val; // RL19
			default: taken = 1'b0;
		endcase
	end
	assign rb.ra_a = src_addr;
	assign rb.ra_b = dst_addr;
	assign rb.ra_p = {7'h00, issue_rsel[0]};
	// Next state: sequencing, architectural registers and memory requests.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		ready_d = ready_q;
		retire_d = 1'b0;
		pend_d = pend_q;
		acc_d = acc_q;
		cy_d = cy_q;
		pc_d = pc_q;
		dp_d = dp_q;
		sp_d = sp_q;
		xa_d = xa_q;
		xw_d = xw_q;
		ca_d = ca_q;
		xwr_d = 1'b0;
		xrd_d = 1'b0;
		crd_d = 1'b0;
		rb.we = 1'b0;
		rb.wa = dst_addr;
		rb.wd = rb.rd_a;
		// Countdown holds the next instruction off until the count has elapsed.
		if (st_q == ST_BUSY) begin
			cnt_d = 3'(cnt_q - 3'd1); // RL22
			if (cnt_q == CYC_ONE) begin
				st_d = ST_IDLE;
				ready_d = 1'b1;
				retire_d = 1'b1;
				pend_d = 2'b00;
				if (pend_q[1]) begin
					acc_d = c_rdata; // RL9
				end else if (pend_q[0]) begin
					acc_d = x_rdata; // RL7
				end
			end
		end
		if (accept) begin
			pc_d = taken ? 16'(pc_seq + rel16) : pc_seq;
			if (dec_cyc > CYC_ONE) begin
				st_d = ST_BUSY; // RL22
				cnt_d = 3'(dec_cyc - 3'd1);
				ready_d = 1'b0;
			end else begin
				retire_d = 1'b1;
			end
			case (issue_op)
				and_op, or_op, xor_op, move_op: begin
					if (issue_dst == LOC_ACC) begin
						acc_d = (issue_op == move_op) ? src_val : alu_res; // RL6
					end else begin
						rb.we = 1'b1; // RL3 RL10
						rb.wd = (issue_op == move_op) ? src_val : alu_res;
					end
				end
				clear_acc_op, complement_op, rotate_left_op, rotate_left_carry_op, rotate_right_op,
				rotate_right_carry_op, swap_op: begin
					acc_d = alu_res; // RL4 RL5
					cy_d = alu_cy; // RL23
				end
				load_pointer_op: dp_d = {issue_arg1, issue_arg2}; // RL11
				code_lookup_op, code_lookup_pc_op: begin
					ca_d = (issue_op == code_lookup_op) ? 16'(dp_q + {8'h00, acc_q})
						: 16'(pc_seq + {8'h00, acc_q}); // RL9
					crd_d = 1'b1;
					pend_d = 2'b10;
				end
				external_read_op: begin
					xa_d = (issue_src == LOC_IND) ? {PTR_PAGE, ptr} : dp_q; // RL7 RL8
					xrd_d = 1'b1;
					pend_d = 2'b01;
				end
				external_write_op: begin
					xa_d = (issue_dst == LOC_IND) ? {PTR_PAGE, ptr} : dp_q; // RL7 RL8
					xw_d = acc_q;
					xwr_d = 1'b1;
				end
				push_op: begin
					sp_d = 8'(sp_q + 8'h01); // RL12
					rb.we = 1'b1;
				end
				pop_op: begin
					sp_d = 8'(sp_q - 8'h01); // RL12
					rb.we = 1'b1;
				end
				exchange_op: begin
					acc_d = rb.rd_a; // RL13
					rb.we = 1'b1;
					rb.wa = src_addr;
					rb.wd = acc_q;
				end
				low_digit_exchange_op: begin
					acc_d = {acc_q[7:4], rb.rd_a[3:0]}; // RL13
					rb.we = 1'b1;
					rb.wa = src_addr;
					rb.wd = {rb.rd_a[7:4], acc_q[3:0]};
				end
				carry_clear_op: cy_d = 1'b0; // RL15
				carry_set_op: cy_d = 1'b1; // RL15
				carry_complement_op: cy_d = !cy_q; // RL15
				carry_and_bit_op: cy_d = cy_q & bit_val; // RL16
				carry_and_not_bit_op: cy_d = cy_q & !bit_val; // RL16
				carry_or_bit_op: cy_d = cy_q | bit_val; // RL16
				carry_or_not_bit_op: cy_d = cy_q | !bit_val; // RL16
				bit_to_carry_op: cy_d = bit_val; // RL17
				bit_clear_op, bit_set_op, bit_complement_op, carry_to_bit_op: begin
					rb.we = 1'b1; // RL15 RL17
					rb.wd[bit_idx] = (issue_op == bit_clear_op) ? 1'b0 : (issue_op == bit_set_op) ? 1'b1
						: (issue_op == carry_to_bit_op) ? cy_q : !bit_val;
				end
				jump_on_bit_and_clear: begin
					rb.we = bit_val; // RL19
					rb.wd[bit_idx] = 1'b0;
				end
				default: rb.we = 1'b0;
			endcase
		end
	end
	// State flip-flops.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q <= ST_IDLE;
			cnt_q <= 3'h0;
			ready_q <= 1'b1;
			retire_q <= 1'b0;
			pend_q <= 2'b00;
			acc_q <= ACC_RESET;
			cy_q <= 1'b0;
			pc_q <= PC_RESET;
			dp_q <= DP_RESET;
			sp_q <= SP_RESET;
			xa_q <= 16'h0000;
			xw_q <= 8'h00;
			ca_q <= 16'h0000;
			xwr_q <= 1'b0;
			xrd_q <= 1'b0;
			crd_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			ready_q <= ready_d;
			retire_q <= retire_d;
			pend_q <= pend_d;
			acc_q <= acc_d;
			cy_q <= cy_d;
			pc_q <= pc_d;
			dp_q <= dp_d;
			sp_q <= sp_d;
			xa_q <= xa_d;
			xw_q <= xw_d;
			ca_q <= ca_d;
			xwr_q <= xwr_d;
			xrd_q <= xrd_d;
			crd_q <= crd_d;
		end
	end
	// Outputs come straight from flip-flops.
	assign issue_ready = ready_q;
	assign retire = retire_q;
	assign acc = acc_q;
	assign carry = cy_q;
	assign pc = pc_q;
	assign data_pointer = dp_q;
	assign stack_ptr = sp_q;
	assign x_addr = xa_q;
	assign x_wdata = xw_q;
	assign x_wr = xwr_q;
	assign x_rd = xrd_q;
	assign c_addr = ca_q;
	assign c_rd = crd_q;
	// Checks on timing and results.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	AST_ONE_CYCLE: assert property (accept && dec_cyc == 3'd1 |=> ready_q && retire_q) // RL22
		else $error("one-cycle instruction stalled the core");
	AST_THREE_CYCLE: assert property (accept && dec_cyc == 3'd3 |=> !ready_q [*2] ##1 ready_q) // RL22
		else $error("three-cycle instruction has wrong length");
	AST_FIVE_CYCLE: assert property (accept && dec_cyc == 3'd5 |=> !ready_q [*4] ##1 ready_q && retire_q) // RL19
		else $error("five-cycle instruction has wrong length");
	AST_AND_IMM: assert property (accept && issue_op == and_op && issue_dst == LOC_ACC && issue_src == LOC_IMM
		|=> acc_q == ($past(acc_q) & $past(issue_arg1))) // RL1
		else $error("accumulator AND with immediate gave wrong value");
	AST_REG_LOGIC: assert property (accept && issue_op inside {and_op, or_op, xor_op} && issue_dst == LOC_ACC
		&& issue_src == LOC_REG |=> pc_q == $past(pc_q) + 16'd1 && ready_q) // RL2
		else $error("register logic op length or time wrong");
	AST_DIR_LOGIC: assert property (accept && issue_op inside {and_op, or_op, xor_op} && issue_dst == LOC_DIR
		&& issue_src == LOC_IMM |=> pc_q == $past(pc_q) + 16'd3 && !ready_q ##1 !ready_q ##1 ready_q) // RL3
		else $error("direct logic op with immediate has wrong timing");
	AST_SWAP: assert property (accept && issue_op == swap_op |=> acc_q == {$past(acc_q[3:0]), $past(acc_q[7:4])}) // RL5
		else $error("nibble swap wrong");
	AST_ROT_CARRY: assert property (accept && issue_op == rotate_left_carry_op
		|=> {cy_q, acc_q} == {$past(acc_q), $past(cy_q)}) // RL23
		else $error("rotate left through carry broke the ring");
	AST_XREAD_PTR: assert property (accept && issue_op == external_read_op && issue_src == LOC_IND
		|=> xrd_q && xa_q == {PTR_PAGE, $past(ptr)} && !ready_q ##1 !xrd_q && !ready_q
		##1 !ready_q ##1 ready_q) // RL8
		else $error("external read through 8-bit pointer wrong");
	AST_LOOKUP: assert property (accept && issue_op == code_lookup_op
		|=> crd_q && ca_q == 16'($past(dp_q) + {8'h00, $past(acc_q)})) // RL9
		else $error("code lookup address wrong");
	AST_PUSH: assert property (accept && issue_op == push_op |=> sp_q == 8'($past(sp_q) + 8'h01)) // RL12
		else $error("push did not advance the stack pointer");
	AST_JUMP_CARRY: assert property (accept && issue_op == jump_on_carry && cy_q
		|=> pc_q == 16'($past(pc_q) + 16'd2 + $past(rel16))) // RL18
		else $error("carry jump target wrong");

	COV_BIT_CLEAR_JUMP: cover property (accept && issue_op == jump_on_bit_and_clear && bit_val);
	COV_EXT_WRITE: cover property (accept && issue_op == external_write_op ##[1:4] ready_q);
	COV_BACK_TO_BACK: cover property (accept && dec_cyc == 3'd1 ##1 accept);
endmodule
`default_nettype wire

/* File: tb/clm_mem_model.sv */
// External data memory and program memory model facing the execution core.
`timescale 1ns/10ps
`default_nettype none
module clm_mem_model (
	input wire logic ref_clk, // Core clock.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic [15:0] x_addr, // External data address.
	input wire logic [7:0] x_wdata, // External write data.
	input wire logic x_wr, // External write strobe.
	input wire logic x_rd, // External read strobe.
	input wire logic [15:0] c_addr, // Program memory address.
	input wire logic c_rd, // Program memory read strobe.
	input wire logic retire, // Instruction finished.
	output logic [7:0] x_rdata, // External read data.
	output logic [7:0] c_rdata // Program memory data.
);
	logic [7:0] xm [256];
	logic x_hold;
	logic c_hold;

	// Data is held from the cycle after a strobe until retire, and scrambled every cycle otherwise.
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 256; i++) begin
				xm[i] <= 8'(i) ^ 8'ha5;
			end
			x_rdata <= 8'h00;
			c_rdata <= 8'h00;
			x_hold <= 1'b0;
			c_hold <= 1'b0;
		end else begin
			if (x_wr) begin
				xm[x_addr[7:0]] <= x_wdata;
			end
			if (x_rd) begin
				x_rdata <= xm[x_addr[7:0]];
				x_hold <= 1'b1;
			end else if (retire || !x_hold) begin
				x_rdata <= ~x_rdata;
				x_hold <= 1'b0;
			end
			if (c_rd) begin
				c_rdata <= c_addr[7:0] + c_addr[15:8] ^ 8'h3c;
				c_hold <= 1'b1;
			end else if (retire || !c_hold) begin
				c_rdata <= ~c_rdata;
				c_hold <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/cpu_logic_move_bit_exec_tb.sv */
// Self-checking testbench for the logic, move and bit execution core.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
	failures++; $display("[FAIL] %0t got %0h expected %0h", $time, got, exp); end end
module cpu_logic_move_bit_exec_tb import clm_pkg::*;;
	typedef struct {clm_op_t op; clm_loc_t d; clm_loc_t s; logic [2:0] r; logic [7:0] a1; logic [7:0] a2;
		int n; logic [7:0] ea; logic ec; logic [15:0] ep;} clm_tb_ins_t;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic issue_valid = 1'b0;
	clm_op_t issue_op = nop_op;
	clm_loc_t issue_dst = LOC_ACC;
	clm_loc_t issue_src = LOC_ACC;
	logic [2:0] issue_rsel = 3'h0;
	logic [7:0] issue_arg1 = 8'h00;
	logic [7:0] issue_arg2 = 8'h00;
	logic issue_ready, retire, carry, x_wr, x_rd, c_rd;
	logic [7:0] acc, stack_ptr, x_wdata, x_rdata, c_rdata;
	logic [15:0] pc, data_pointer, x_addr, c_addr;
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;
	int a;
	int aq[$];
	clm_tb_ins_t prog[$];
	clm_tb_ins_t eq[$];
	clm_tb_ins_t e;
	logic [7:0] ea = 8'h00;
	logic ec = 1'b0;
	logic [15:0] ep = 16'h0000;
	logic [15:0] a16;
	logic [7:0] r1, r2, r3;

	clm_core DUT (.ref_clk(ref_clk), .rst(rst), .issue_valid(issue_valid), .issue_op(issue_op),
		.issue_dst(issue_dst), .issue_src(issue_src), .issue_rsel(issue_rsel), .issue_arg1(issue_arg1),
		.issue_arg2(issue_arg2), .issue_ready(issue_ready), .retire(retire), .acc(acc), .carry(carry), .pc(pc),
		.data_pointer(data_pointer), .stack_ptr(stack_ptr), .x_addr(x_addr), .x_wdata(x_wdata), .x_wr(x_wr),
		.x_rd(x_rd), .x_rdata(x_rdata), .c_addr(c_addr), .c_rd(c_rd), .c_rdata(c_rdata));
	clm_mem_model MEM (.ref_clk(ref_clk), .rst(rst), .x_addr(x_addr), .x_wdata(x_wdata), .x_wr(x_wr),
		.x_rd(x_rd), .c_addr(c_addr), .c_rd(c_rd), .retire(retire), .x_rdata(x_rdata), .c_rdata(c_rdata));

	// The clock runs at 20 MHz.
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end

	// Prints the counts and the verdict, then stops.
	task automatic finish_test();
		$display("Counts: mismatches %0d, comparisons %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Appends one instruction with its expected state after retire.
	task automatic add(input clm_op_t op, input clm_loc_t d, input clm_loc_t s, input logic [2:0] r,
		input logic [7:0] a1, input logic [7:0] a2, input int n, input int len, input logic [15:0] rel);
		ep = ep + 16'(len) + rel;
		prog.push_back('{op, d, s, r, a1, a2, n, ea, ec, ep});
	endtask

	// Checks the state that reset leaves behind.
	task automatic chk_reset();
		@(negedge ref_clk);
		`CHK(issue_ready, 1'b1)
		`CHK(acc, 8'h00)
		`CHK(carry, 1'b0)
		`CHK(pc, 16'h0000)
		`CHK(data_pointer, 16'h0000)
		`CHK(stack_ptr, 8'h07)
	endtask

	// Records accept edges, counts cycles and cuts a hang short.
	always @(posedge ref_clk) begin
		if (issue_valid && issue_ready && !rst) begin
			aq.push_back(cyc);
		end
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			finish_test();
		end
	end

	// Each retire takes the oldest note and compares state and cycle count.
	always @(negedge ref_clk) begin
		if (retire === 1'b1 && eq.size() > 0) begin
			e = eq.pop_front();
			a = aq.pop_front();
			`CHK(acc, e.ea)
			`CHK(carry, e.ec)
			`CHK(pc, e.ep)
			`CHK(cyc - a, e.n)
		end
	end

	// Builds the program, drives it back to back and finishes with a second reset.
	initial begin
		void'($urandom(32'h5a6e));
		r1 = 8'($urandom);
		r2 = 8'($urandom);
		r3 = 8'($urandom);
		ea = r1; add(move_op, LOC_ACC, LOC_IMM, 3'h0, r1, 8'h00, 2, 2, 16'h0000);
		add(move_op, LOC_REG, LOC_ACC, 3'h2, 8'h00, 8'h00, 1, 1, 16'h0000);
		ea = r2; add(move_op, LOC_ACC, LOC_IMM, 3'h0, r2, 8'h00, 2, 2, 16'h0000);
		ea = r2 & r1; add(and_op, LOC_ACC, LOC_IMM, 3'h0, r1, 8'h00, 2, 2, 16'h0000);
		ea = ea | r3; add(or_op, LOC_ACC, LOC_IMM, 3'h0, r3, 8'h00, 2, 2, 16'h0000);
		ea = ea ^ r1; add(xor_op, LOC_ACC, LOC_REG, 3'h2, 8'h00, 8'h00, 1, 1, 16'h0000);
		add(move_op, LOC_DIR, LOC_ACC, 3'h0, 8'h30, 8'h00, 2, 2, 16'h0000);
		add(xor_op, LOC_DIR, LOC_IMM, 3'h0, 8'h30, r2, 3, 3, 16'h0000);
		ea = ea ^ r2; add(move_op, LOC_ACC, LOC_DIR, 3'h0, 8'h30, 8'h00, 2, 2, 16'h0000);
		a16 = {8'h00, ea}; add(push_op, LOC_ACC, LOC_ACC, 3'h0, 8'h30, 8'h00, 3, 2, 16'h0000);
		ea = ~ea; add(complement_op, LOC_ACC, LOC_ACC, 3'h0, 8'h00, 8'h00, 1, 1, 16'h0000);
		{ec, ea} = {ea, ec}; add(rotate_left_carry_op, LOC_ACC, LOC_ACC, 3'h0, 8'h00, 8'h00, 1, 1, 16'h0000);
		ea = {ea[0], ea[7:1]}; add(rotate_right_op, LOC_ACC, LOC_ACC, 3'h0, 8'h00, 8'h00, 1, 1, 16'h0000);
		ea = {ea[3:0], ea[7:4]}; add(swap_op, LOC_ACC, LOC_ACC, 3'h0, 8'h00, 8'h00, 1, 1, 16'h0000);
		ec = 1'b1; add(carry_set_op, LOC_ACC, LOC_ACC, 3'h0, 8'h00, 8'h00, 1, 1, 16'h0000);
		add(jump_on_carry, LOC_ACC, LOC_ACC, 3'h0, 8'h04, 8'h00, 3, 2, 16'h0004);
		add(jump_on_no_carry, LOC_ACC, LOC_ACC, 3'h0, 8'h04, 8'h00, 3, 2, 16'h0000);
		add(bit_set_op, LOC_ACC, LOC_ACC, 3'h0, 8'h05, 8'h00, 3, 2, 16'h0000);
		ea = 8'h20; add(move_op, LOC_ACC, LOC_DIR, 3'h0, 8'h20, 8'h00, 2, 2, 16'h0000);
		add(jump_on_bit_and_clear, LOC_ACC, LOC_ACC, 3'h0, 8'h05, 8'hfe, 5, 3, 16'hfffe);
		ec = 1'b0; add(carry_clear_op, LOC_ACC, LOC_ACC, 3'h0, 8'h00, 8'h00, 1, 1, 16'h0000);
		add(jump_on_no_bit, LOC_ACC, LOC_ACC, 3'h0, 8'h05, 8'h06, 5, 3, 16'h0006);
		ec = 1'b1; add(carry_or_not_bit_op, LOC_ACC, LOC_ACC, 3'h0, 8'h05, 8'h00, 2, 2, 16'h0000);
		ea = a16[7:0]; add(exchange_op, LOC_ACC, LOC_DIR, 3'h0, 8'h08, 8'h00, 3, 2, 16'h0000);
		ea = 8'h00; add(move_op, LOC_ACC, LOC_DIR, 3'h0, 8'h20, 8'h00, 2, 2, 16'h0000);
		add(load_pointer_op, LOC_ACC, LOC_IMM, 3'h0, r1, r2, 3, 3, 16'h0000);
		ea = r3; add(move_op, LOC_ACC, LOC_IMM, 3'h0, r3, 8'h00, 2, 2, 16'h0000);
		add(external_write_op, LOC_ACC, LOC_ACC, 3'h0, 8'h00, 8'h00, 4, 1, 16'h0000);
		ea = 8'h00; add(clear_acc_op, LOC_ACC, LOC_ACC, 3'h0, 8'h00, 8'h00, 1, 1, 16'h0000);
		ea = r3; add(external_read_op, LOC_ACC, LOC_ACC, 3'h0, 8'h00, 8'h00, 3, 1, 16'h0000);
		a16 = {r1, r2} + {8'h00, ea};
		ea = a16[7:0] + a16[15:8] ^ 8'h3c; add(code_lookup_op, LOC_ACC, LOC_ACC, 3'h0, 8'h00, 8'h00, 5, 1, 16'h0000);
		add(move_op, LOC_REG, LOC_IMM, 3'h0, 8'h40, 8'h00, 2, 2, 16'h0000);
		add(external_write_op, LOC_IND, LOC_ACC, 3'h0, 8'h00, 8'h00, 5, 1, 16'h0000);
		a16 = {8'h00, ea}; ea = 8'h00; add(clear_acc_op, LOC_ACC, LOC_ACC, 3'h0, 8'h00, 8'h00, 1, 1, 16'h0000);
		ea = a16[7:0]; add(external_read_op, LOC_ACC, LOC_IND, 3'h0, 8'h00, 8'h00, 4, 1, 16'h0000);
		ea = r1; add(exchange_op, LOC_ACC, LOC_REG, 3'h2, 8'h00, 8'h00, 2, 1, 16'h0000);
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		chk_reset();
		@(posedge ref_clk);
		foreach (prog[i]) begin
			issue_valid <= 1'b1;
			issue_op <= prog[i].op;
			issue_dst <= prog[i].d;
			issue_src <= prog[i].s;
			issue_rsel <= prog[i].r;
			issue_arg1 <= prog[i].a1;
			issue_arg2 <= prog[i].a2;
			eq.push_back(prog[i]);
			do @(posedge ref_clk); while (issue_ready !== 1'b1);
		end
		issue_valid <= 1'b0;
		for (int k = 0; k < 20 && eq.size() > 0; k++) begin
			@(posedge ref_clk);
		end
		`CHK(eq.size(), 0)
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		chk_reset();
		finish_test();
	end
endmodule
`default_nettype wire
